// File: eieu_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "eieu_defines.svh"

module eieu_core
  import eieu_pkg::*;
#(
  parameter int DM_AW = 11,
  parameter int PM_AW = 12
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_start,
  input wire logic [4:0] i_op,
  input wire logic [2:0] i_bit,
  input wire logic [DM_AW-1:0] i_mem_addr,
  input wire logic [7:0] i_dm_rdata,
  input wire logic [15:0] i_pm_rdata,
  input wire logic [2:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  output logic [DM_AW-1:0] o_dm_addr,
  output logic o_dm_rd,
  output logic o_dm_wr,
  output logic [7:0] o_dm_wdata,
  output logic [PM_AW-1:0] o_pm_addr,
  output logic o_pm_rd,
  output logic [7:0] o_acc,
  output logic [5:0] o_status,
  output logic [7:0] o_table_pointer_low,
  output logic o_busy,
  output logic o_done,
  output logic o_skip
);

  // The high table pointer holds 8 bits, so the program space stops at 16 address bits
  if (PM_AW <= 8 || PM_AW > 16 || DM_AW < 1 || DM_AW > 16) begin : g_bad_width
    $error("eieu_core: unsupported address widths");
  end

  eieu_state_t state, next_state;
  eieu_op_t op, next_op;
  logic [2:0] bit_sel, next_bit_sel;
  logic [7:0] next_acc, next_table_pointer_low, table_pointer_high_full, next_table_pointer_high_full, table_high_byte, next_table_high_byte;
  logic [5:0] next_status;
  logic [7:0] next_reg_rdata, next_dm_wdata;
  logic [DM_AW-1:0] next_dm_addr;
  logic [PM_AW-1:0] next_pm_addr;
  logic next_dm_rd, next_dm_wr, next_pm_rd, next_busy, next_done, next_skip;

  // Datapath on the byte returned by data memory
  logic sub_b, sub_mem, is_sub, sel_bit;
  logic [8:0] diff9;
  logic [4:0] lo5;
  logic [7:0] sub_res, dec_v, inc_v, swap_v, xor_v, bit_mask;
  logic sub_ov, acc_ge;
  logic [PM_AW-8-1:0] table_pointer_high;

  assign table_pointer_high = table_pointer_high_full[PM_AW-8-1:0];
  assign is_sub = (op == OP_SUB_BORROW) || (op == OP_SUB_BORROW_MEM) ||
                  (op == OP_SUBTRACT) || (op == OP_SUBTRACT_MEM);
  assign sub_mem = (op == OP_SUB_BORROW_MEM) || (op == OP_SUBTRACT_MEM);
  // Only the borrow forms feed the inverted carry in
  assign sub_b = ((op == OP_SUB_BORROW) || (op == OP_SUB_BORROW_MEM)) &
                 ~o_status[`EIEU_FLAG_C];
  assign diff9 = {1'b0, o_acc} - {1'b0, i_dm_rdata} - {8'h00, sub_b};
  assign lo5 = {1'b0, o_acc[3:0]} - {1'b0, i_dm_rdata[3:0]} - {4'h0, sub_b};
  assign sub_res = diff9[7:0];
  assign sub_ov = (o_acc[7] ^ i_dm_rdata[7]) & (o_acc[7] ^ sub_res[7]);
  assign acc_ge = {1'b0, o_acc} >= ({1'b0, i_dm_rdata} + {8'h00, sub_b});
  assign dec_v = i_dm_rdata - 8'h01;
  assign inc_v = i_dm_rdata + 8'h01;
  assign swap_v = {i_dm_rdata[3:0], i_dm_rdata[7:4]};
  assign xor_v = o_acc ^ i_dm_rdata;
  assign bit_mask = 8'h01 << bit_sel;
  assign sel_bit = i_dm_rdata[bit_sel];

  always_comb begin
    logic take;
    logic is_table;
    take = 1'b0;
    is_table = (i_op == OP_TABLE_READ_PAGE) || (i_op == OP_TABLE_READ_FINAL) ||
               (i_op == OP_TABLE_READ_PAGE_INC) || (i_op == OP_TABLE_READ_FINAL_INC);
    next_state = state;
    next_op = op;
    next_bit_sel = bit_sel;
    next_acc = o_acc;
    next_status = o_status;
    next_table_pointer_low = o_table_pointer_low;
    next_table_pointer_high_full = table_pointer_high_full;
    next_table_high_byte = table_high_byte;
    next_dm_addr = o_dm_addr;
    next_dm_wdata = o_dm_wdata;
    next_pm_addr = o_pm_addr;
    next_dm_rd = 1'b0;
    next_dm_wr = 1'b0;
    next_pm_rd = 1'b0;
    next_busy = o_busy;
    next_done = 1'b0;
    next_skip = o_skip;
    next_reg_rdata = 8'h00;
    // Software writes land first so the engine's own update wins a clash
    if (i_reg_wr) begin
      case (i_reg_addr)
        `EIEU_REG_ACC: next_acc = i_reg_wdata;
        `EIEU_REG_STATUS: next_status = i_reg_wdata[5:0];
        `EIEU_REG_TABLE_POINTER_LOW: next_table_pointer_low = i_reg_wdata;
        `EIEU_REG_TABLE_POINTER_HIGH: next_table_pointer_high_full = i_reg_wdata;
        `EIEU_REG_TABLE_HIGH_BYTE: next_table_high_byte = i_reg_wdata;
        default: ;
      endcase
    end
    if (i_reg_rd) begin
      case (i_reg_addr)
        `EIEU_REG_ACC: next_reg_rdata = o_acc;
        `EIEU_REG_STATUS: next_reg_rdata = {2'b00, o_status};
        `EIEU_REG_TABLE_POINTER_LOW: next_reg_rdata = o_table_pointer_low;
        `EIEU_REG_TABLE_POINTER_HIGH: next_reg_rdata = 8'({table_pointer_high});
        `EIEU_REG_TABLE_HIGH_BYTE: next_reg_rdata = table_high_byte;
        `EIEU_REG_CTRL: next_reg_rdata = {6'h00, o_skip, o_busy};
        default: next_reg_rdata = 8'h00;
      endcase
    end
    case (state)
      S_IDLE: begin
        if (i_start) begin
          next_op = eieu_op_t'(i_op);
          next_bit_sel = i_bit;
          next_dm_addr = i_mem_addr;
          next_busy = 1'b1;
          next_skip = 1'b0;
          if (is_table) begin
            if ((i_op == OP_TABLE_READ_PAGE_INC) || (i_op == OP_TABLE_READ_FINAL_INC)) begin
              next_state = S_TINC;
            end else begin
              next_state = S_TRD;
            end
          end else begin
            next_dm_rd = 1'b1;
            next_state = S_FETCH;
          end
        end
      end
      S_FETCH: next_state = S_EXEC;
      S_EXEC: begin
        case (op)
          OP_SUB_BORROW, OP_SUB_BORROW_MEM, OP_SUBTRACT, OP_SUBTRACT_MEM: begin
            if (sub_mem) begin
              next_dm_wr = 1'b1;
              next_dm_wdata = sub_res;
            end else begin
              next_acc = sub_res;
            end
            next_status[`EIEU_FLAG_C] = ~diff9[8];
            next_status[`EIEU_FLAG_AC] = ~lo5[4];
            next_status[`EIEU_FLAG_Z] = (sub_res == 8'h00);
            next_status[`EIEU_FLAG_OV] = sub_ov;
            next_status[`EIEU_FLAG_SC] = sub_ov ^ sub_res[7];
            // Carry-zero chains across a multi-byte borrow sequence
            if ((op == OP_SUB_BORROW) || (op == OP_SUB_BORROW_MEM)) begin
              next_status[`EIEU_FLAG_CZ] = (sub_res == 8'h00) & o_status[`EIEU_FLAG_CZ];
            end else begin
              next_status[`EIEU_FLAG_CZ] = (sub_res == 8'h00);
            end
          end
          OP_DEC_SKIP_ZERO: begin
            next_dm_wr = 1'b1;
            next_dm_wdata = dec_v;
            take = (dec_v == 8'h00);
          end
          OP_DEC_SKIP_ZERO_ACC: begin
            next_acc = dec_v;
            take = (dec_v == 8'h00);
          end
          OP_INC_SKIP_ZERO: begin
            next_dm_wr = 1'b1;
            next_dm_wdata = inc_v;
            take = (inc_v == 8'h00);
          end
          OP_INC_SKIP_ZERO_ACC: begin
            next_acc = inc_v;
            take = (inc_v == 8'h00);
          end
          OP_SET_ONES: begin
            next_dm_wr = 1'b1;
            next_dm_wdata = `EIEU_ALL_ONES;
          end
          OP_SET_BIT: begin
            next_dm_wr = 1'b1;
            next_dm_wdata = i_dm_rdata | bit_mask;
          end
          OP_SKIP_NONZERO: take = (i_dm_rdata != 8'h00);
          OP_SKIP_NONZERO_BIT: take = sel_bit;
          OP_SKIP_ZERO: take = (i_dm_rdata == 8'h00);
          OP_SKIP_ZERO_BIT: take = ~sel_bit;
          OP_MOVE_SKIP_ZERO: begin
            next_acc = i_dm_rdata;
            take = (i_dm_rdata == 8'h00);
          end
          OP_NIBBLE_EXCHANGE: begin
            next_dm_wr = 1'b1;
            next_dm_wdata = swap_v;
          end
          OP_NIBBLE_EXCHANGE_ACC: next_acc = swap_v;
          OP_EXCLUSIVE_OR: begin
            next_acc = xor_v;
            next_status[`EIEU_FLAG_Z] = (xor_v == 8'h00);
          end
          OP_EXCLUSIVE_OR_MEM: begin
            next_dm_wr = 1'b1;
            next_dm_wdata = xor_v;
            next_status[`EIEU_FLAG_Z] = (xor_v == 8'h00);
          end
          default: ;
        endcase
        if (take) begin
          next_skip = 1'b1;
          next_state = S_DUMMY;
        end else begin
          next_done = 1'b1;
          next_busy = 1'b0;
          next_state = S_IDLE;
        end
      end
      S_DUMMY: begin
        next_done = 1'b1;
        next_busy = 1'b0;
        next_state = S_IDLE;
      end
      S_TINC: begin
        next_table_pointer_low = o_table_pointer_low + 8'h01;
        next_state = S_TRD;
      end
      S_TRD: begin
        next_pm_rd = 1'b1;
        if ((op == OP_TABLE_READ_FINAL) || (op == OP_TABLE_READ_FINAL_INC)) begin
          next_pm_addr = {{(PM_AW-8){1'b1}}, o_table_pointer_low};
        end else begin
          next_pm_addr = {table_pointer_high, o_table_pointer_low};
        end
        next_state = S_TWAIT;
      end
      S_TWAIT: next_state = S_TEXEC;
      S_TEXEC: begin
        next_dm_wr = 1'b1;
        next_dm_wdata = i_pm_rdata[7:0];
        next_table_high_byte = i_pm_rdata[15:8];
        next_done = 1'b1;
        next_busy = 1'b0;
        next_state = S_IDLE;
      end
      default: begin
        next_busy = 1'b0;
        next_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= S_IDLE;
      op <= OP_SUB_BORROW;
      bit_sel <= 3'h0;
      o_acc <= `EIEU_RST_ACC;
      o_status <= `EIEU_RST_FLAGS;
      o_table_pointer_low <= `EIEU_RST_BYTE;
      table_pointer_high_full <= `EIEU_RST_BYTE;
      table_high_byte <= `EIEU_RST_BYTE;
      o_dm_addr <= '0;
      o_dm_rd <= 1'b0;
      o_dm_wr <= 1'b0;
      o_dm_wdata <= `EIEU_RST_BYTE;
      o_pm_addr <= '0;
      o_pm_rd <= 1'b0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_skip <= 1'b0;
      o_reg_rdata <= `EIEU_RST_BYTE;
    end else begin
      state <= next_state;
      op <= next_op;
      bit_sel <= next_bit_sel;
      o_acc <= next_acc;
      o_status <= next_status;
      o_table_pointer_low <= next_table_pointer_low;
      table_pointer_high_full <= next_table_pointer_high_full;
      table_high_byte <= next_table_high_byte;
      o_dm_addr <= next_dm_addr;
      o_dm_rd <= next_dm_rd;
      o_dm_wr <= next_dm_wr;
      o_dm_wdata <= next_dm_wdata;
      o_pm_addr <= next_pm_addr;
      o_pm_rd <= next_pm_rd;
      o_busy <= next_busy;
      o_done <= next_done;
      o_skip <= next_skip;
      o_reg_rdata <= next_reg_rdata;
    end
  end

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_nrst);

  property p_sbc_acc;
    (state == S_EXEC && op == OP_SUB_BORROW && !i_reg_wr) |=>
      o_acc == 8'($past(o_acc) - $past(i_dm_rdata) - {7'h00, ~$past(o_status[`EIEU_FLAG_C])});
  endproperty
  a_sbc_acc: assert property (p_sbc_acc) else $error("borrow subtract result wrong");
  property p_sub_carry;
    (state == S_EXEC && is_sub && !i_reg_wr) |=> o_status[`EIEU_FLAG_C] == $past(acc_ge);
  endproperty
  a_sub_carry: assert property (p_sub_carry) else $error("subtract carry wrong");
  property p_sbc_mem;
    (state == S_EXEC && op == OP_SUB_BORROW_MEM && !i_reg_wr) |=>
      o_dm_wr && o_dm_wdata == $past(sub_res) && $stable(o_acc);
  endproperty
  a_sbc_mem: assert property (p_sbc_mem) else $error("memory subtract wrong");
  property p_sub_zero;
    (state == S_EXEC && is_sub && !i_reg_wr) |=>
      o_status[`EIEU_FLAG_Z] == ($past(o_acc) == $past(i_dm_rdata) + {7'h00, $past(sub_b)});
  endproperty
  a_sub_zero: assert property (p_sub_zero) else $error("subtract zero flag wrong");
  property p_dec_mem;
    (state == S_EXEC && op == OP_DEC_SKIP_ZERO) |=>
      o_dm_wr && o_dm_wdata == 8'($past(i_dm_rdata) - 8'h01);
  endproperty
  a_dec_mem: assert property (p_dec_mem) else $error("decrement write wrong");
  sequence s_skip_taken;
    state == S_EXEC && next_state == S_DUMMY;
  endsequence
  sequence s_dummy_then_done;
    !o_done ##1 (o_done && o_skip && !o_busy);
  endsequence
  property p_skip_dummy;
    s_skip_taken |=> s_dummy_then_done;
  endproperty
  a_skip_dummy: assert property (p_skip_dummy) else $error("skip missed dummy cycle");
  property p_set_ones;
    (state == S_EXEC && op == OP_SET_ONES && !i_reg_wr) |=>
      o_dm_wr && o_dm_wdata == `EIEU_ALL_ONES && $stable(o_status);
  endproperty
  a_set_ones: assert property (p_set_ones) else $error("byte set wrong");
  property p_skip_zero;
    (state == S_EXEC && op == OP_SKIP_ZERO && !i_reg_wr) |=>
      (o_skip == ($past(i_dm_rdata) == 8'h00)) && !o_dm_wr && $stable(o_acc);
  endproperty
  a_skip_zero: assert property (p_skip_zero) else $error("zero test wrong");
  property p_swap;
    (state == S_EXEC && op == OP_NIBBLE_EXCHANGE) |=>
      o_dm_wr && o_dm_wdata == {$past(i_dm_rdata[3:0]), $past(i_dm_rdata[7:4])};
  endproperty
  a_swap: assert property (p_swap) else $error("nibble exchange wrong");
  sequence s_preinc_start;
    state == S_IDLE && i_start && i_op == OP_TABLE_READ_PAGE_INC && !i_reg_wr;
  endsequence
  property p_preinc;
    s_preinc_start ##1 !i_reg_wr |=>
      ##1 (o_pm_rd && o_pm_addr[7:0] == 8'($past(o_table_pointer_low, 3) + 8'h01));
  endproperty
  a_preinc: assert property (p_preinc) else $error("pointer not bumped first");
  property p_xor_flags;
    (state == S_EXEC && op == OP_EXCLUSIVE_OR && !i_reg_wr) |=>
      o_acc == ($past(o_acc) ^ $past(i_dm_rdata)) &&
      o_status[`EIEU_FLAG_C] == $past(o_status[`EIEU_FLAG_C]) &&
      o_status[`EIEU_FLAG_OV] == $past(o_status[`EIEU_FLAG_OV]);
  endproperty
  a_xor_flags: assert property (p_xor_flags) else $error("xor flags wrong");
  property p_table_flags;
    (state == S_TEXEC && !i_reg_wr) |=> $stable(o_status) && o_dm_wr;
  endproperty
  a_table_flags: assert property (p_table_flags) else $error("table read touched flags");

endmodule

`default_nettype wire

// File: eieu_defines.svh
`ifndef EIEU_DEFINES_SVH
`define EIEU_DEFINES_SVH

// Register indices on the software port
`define EIEU_REG_ACC 3'h0
`define EIEU_REG_STATUS 3'h1
`define EIEU_REG_TABLE_POINTER_LOW 3'h2
`define EIEU_REG_TABLE_POINTER_HIGH 3'h3
`define EIEU_REG_TABLE_HIGH_BYTE 3'h4
`define EIEU_REG_CTRL 3'h5

// Status flag bit positions
`define EIEU_FLAG_C 0
`define EIEU_FLAG_AC 1
`define EIEU_FLAG_Z 2
`define EIEU_FLAG_OV 3
`define EIEU_FLAG_SC 4
`define EIEU_FLAG_CZ 5

// Control/status register fields
`define EIEU_CTRL_BUSY 0
`define EIEU_CTRL_SKIP 1

// Reset values
`define EIEU_RST_ACC 8'h00
`define EIEU_RST_FLAGS 6'h00
`define EIEU_RST_BYTE 8'h00

// Fill value of the byte-set instruction
`define EIEU_ALL_ONES 8'hFF

`endif

// File: eieu_pkg.sv
package eieu_pkg;

  typedef enum logic [4:0] {
    OP_SUB_BORROW = 5'h00,
    OP_SUB_BORROW_MEM = 5'h01,
    OP_SUBTRACT = 5'h02,
    OP_SUBTRACT_MEM = 5'h03,
    OP_DEC_SKIP_ZERO = 5'h04,
    OP_DEC_SKIP_ZERO_ACC = 5'h05,
    OP_INC_SKIP_ZERO = 5'h06,
    OP_INC_SKIP_ZERO_ACC = 5'h07,
    OP_SET_ONES = 5'h08,
    OP_SET_BIT = 5'h09,
    OP_SKIP_NONZERO = 5'h0A,
    OP_SKIP_NONZERO_BIT = 5'h0B,
    OP_SKIP_ZERO = 5'h0C,
    OP_SKIP_ZERO_BIT = 5'h0D,
    OP_MOVE_SKIP_ZERO = 5'h0E,
    OP_NIBBLE_EXCHANGE = 5'h0F,
    OP_NIBBLE_EXCHANGE_ACC = 5'h10,
    OP_TABLE_READ_PAGE = 5'h11,
    OP_TABLE_READ_FINAL = 5'h12,
    OP_TABLE_READ_PAGE_INC = 5'h13,
    OP_TABLE_READ_FINAL_INC = 5'h14,
    OP_EXCLUSIVE_OR = 5'h15,
    OP_EXCLUSIVE_OR_MEM = 5'h16
  } eieu_op_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_FETCH = 3'b001,
    S_EXEC = 3'b010,
    S_DUMMY = 3'b011,
    S_TINC = 3'b100,
    S_TRD = 3'b101,
    S_TWAIT = 3'b110,
    S_TEXEC = 3'b111
  } eieu_state_t;

endpackage

// File: eieu_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// Data and program memory partner: one cycle of read latency.
// Read data are valid only in the cycle after the strobe and flip every cycle
// otherwise, so a late or early sample by the engine cannot pass by luck.
module eieu_mem_model #(
  parameter int DM_AW = 11,
  parameter int PM_AW = 12
) (
  input wire logic i_sys_clk,
  input wire logic [DM_AW-1:0] i_dm_addr,
  input wire logic i_dm_rd,
  input wire logic i_dm_wr,
  input wire logic [7:0] i_dm_wdata,
  input wire logic [PM_AW-1:0] i_pm_addr,
  input wire logic i_pm_rd,
  output logic [7:0] o_dm_rdata,
  output logic [15:0] o_pm_rdata
);
  logic [7:0] dm [2**DM_AW];
  logic [15:0] pm [2**PM_AW];
  initial begin
    o_dm_rdata = 8'h00;
    o_pm_rdata = 16'h0000;
  end
  always @(posedge i_sys_clk) begin
    if (i_dm_rd) begin
      o_dm_rdata <= dm[i_dm_addr];
    end else begin
      o_dm_rdata <= ~o_dm_rdata;
    end
    if (i_pm_rd) begin
      o_pm_rdata <= pm[i_pm_addr];
    end else begin
      o_pm_rdata <= ~o_pm_rdata;
    end
    if (i_dm_wr) begin
      dm[i_dm_addr] <= i_dm_wdata;
    end
  end
endmodule
`default_nettype wire

// File: eieu_core_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "eieu_defines.svh"
module eieu_core_test import eieu_pkg::*;;
  localparam int DM_AW = 11;
  localparam int PM_AW = 12;
  localparam int LIMIT = 20000;
  localparam logic [DM_AW-1:0] DADDR = 11'h5A3;
  typedef struct packed {
    eieu_op_t op;
    logic [2:0] bt;
    logic [7:0] a0;
    logic [7:0] m;
    logic [7:0] res;
    logic to_acc;
    logic skip;
  } eieu_row_t;
  // Columns: opcode, bit, acc before, memory before, result, result in acc, skip
  eieu_row_t rows [20] = '{
    '{OP_DEC_SKIP_ZERO, 3'h0, 8'h33, 8'h01, 8'h00, 1'b0, 1'b1},
    '{OP_DEC_SKIP_ZERO, 3'h0, 8'h33, 8'h00, 8'hFF, 1'b0, 1'b0},
    '{OP_DEC_SKIP_ZERO_ACC, 3'h0, 8'h33, 8'h01, 8'h00, 1'b1, 1'b1},
    '{OP_INC_SKIP_ZERO, 3'h0, 8'h33, 8'hFF, 8'h00, 1'b0, 1'b1},
    '{OP_INC_SKIP_ZERO_ACC, 3'h0, 8'h33, 8'h7F, 8'h80, 1'b1, 1'b0},
    '{OP_SET_ONES, 3'h0, 8'h33, 8'h12, 8'hFF, 1'b0, 1'b0},
    '{OP_SET_BIT, 3'h7, 8'h33, 8'h00, 8'h80, 1'b0, 1'b0},
    '{OP_SET_BIT, 3'h0, 8'h33, 8'hF0, 8'hF1, 1'b0, 1'b0},
    '{OP_SKIP_NONZERO, 3'h0, 8'h33, 8'h00, 8'h00, 1'b0, 1'b0},
    '{OP_SKIP_NONZERO, 3'h0, 8'h33, 8'h40, 8'h40, 1'b0, 1'b1},
    '{OP_SKIP_NONZERO_BIT, 3'h2, 8'h33, 8'hFB, 8'hFB, 1'b0, 1'b0},
    '{OP_SKIP_NONZERO_BIT, 3'h3, 8'h33, 8'h08, 8'h08, 1'b0, 1'b1},
    '{OP_SKIP_ZERO, 3'h0, 8'h33, 8'h00, 8'h00, 1'b0, 1'b1},
    '{OP_SKIP_ZERO_BIT, 3'h2, 8'h33, 8'h04, 8'h04, 1'b0, 1'b0},
    '{OP_SKIP_ZERO_BIT, 3'h0, 8'h33, 8'hFE, 8'hFE, 1'b0, 1'b1},
    '{OP_MOVE_SKIP_ZERO, 3'h0, 8'h33, 8'h00, 8'h00, 1'b1, 1'b1},
    '{OP_NIBBLE_EXCHANGE, 3'h0, 8'h33, 8'h3C, 8'hC3, 1'b0, 1'b0},
    '{OP_NIBBLE_EXCHANGE_ACC, 3'h0, 8'h33, 8'h5A, 8'hA5, 1'b1, 1'b0},
    '{OP_EXCLUSIVE_OR, 3'h0, 8'h0F, 8'hF0, 8'hFF, 1'b1, 1'b0},
    '{OP_EXCLUSIVE_OR_MEM, 3'h0, 8'h5A, 8'h5A, 8'h00, 1'b0, 1'b0}
  };
  logic [7:0] sa [4] = '{8'h11, 8'h80, 8'h55, 8'h03};
  logic [7:0] sm [4] = '{8'h10, 8'h01, 8'h55, 8'h08};
  logic sc [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  logic i_sys_clk, i_nrst, i_start, i_reg_wr, i_reg_rd;
  logic [4:0] i_op;
  logic [2:0] i_bit, i_reg_addr;
  logic [DM_AW-1:0] i_mem_addr, o_dm_addr;
  logic [7:0] i_dm_rdata, i_reg_wdata, o_reg_rdata, o_dm_wdata, o_acc, o_table_pointer_low, rd_val;
  logic [15:0] i_pm_rdata;
  logic [PM_AW-1:0] o_pm_addr, pa;
  logic o_dm_rd, o_dm_wr, o_pm_rd, o_busy, o_done, o_skip, skp, xo;
  logic [5:0] o_status, st;
  logic [13:0] want;
  eieu_row_t r;
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int n_cyc;

  eieu_core #(.DM_AW(DM_AW), .PM_AW(PM_AW)) eieu_core_i (.i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst), .i_start(i_start), .i_op(i_op), .i_bit(i_bit), .i_mem_addr(i_mem_addr),
    .i_dm_rdata(i_dm_rdata), .i_pm_rdata(i_pm_rdata), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .o_dm_addr(o_dm_addr), .o_dm_rd(o_dm_rd), .o_dm_wr(o_dm_wr),
    .o_dm_wdata(o_dm_wdata), .o_pm_addr(o_pm_addr), .o_pm_rd(o_pm_rd), .o_acc(o_acc),
    .o_status(o_status), .o_table_pointer_low(o_table_pointer_low), .o_busy(o_busy), .o_done(o_done), .o_skip(o_skip));
  eieu_mem_model #(.DM_AW(DM_AW), .PM_AW(PM_AW)) eieu_mem_model_i (.i_sys_clk(i_sys_clk),
    .i_dm_addr(o_dm_addr), .i_dm_rd(o_dm_rd), .i_dm_wr(o_dm_wr), .i_dm_wdata(o_dm_wdata),
    .i_pm_addr(o_pm_addr), .i_pm_rd(o_pm_rd), .o_dm_rdata(i_dm_rdata),
    .o_pm_rdata(i_pm_rdata));

  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp_v);
    tests_run++;
    if (seen !== exp_v) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp_v);
    end
  endtask

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b0;
    #1 d = o_reg_rdata;
  endtask

  // Bounded wait: a hung engine ends the wait after 20 cycles and fails the count check
  task automatic exec(input eieu_op_t op, input logic [2:0] bt, output int n, output logic s);
    @(posedge i_sys_clk);
    i_start <= 1'b1;
    i_op <= op;
    i_bit <= bt;
    i_mem_addr <= DADDR;
    @(posedge i_sys_clk);
    i_start <= 1'b0;
    // The count includes the cycle in which the start request stands
    n = 1;
    do begin
      @(posedge i_sys_clk);
      #1 n++;
    end while (o_done !== 1'b1 && n < 20);
    // One more edge so a memory write issued beside done has landed before the checks
    @(posedge i_sys_clk);
    #1 s = o_skip;
  endtask

  task automatic prep(input logic [7:0] a0, input logic [5:0] s0, input logic [7:0] m);
    reg_wr(`EIEU_REG_ACC, a0);
    reg_wr(`EIEU_REG_STATUS, {2'b00, s0});
    eieu_mem_model_i.dm[DADDR] = m;
  endtask

  // Returns flags and difference; bin is the borrow term
  function automatic logic [13:0] sub_calc(input logic [7:0] a, input logic [7:0] m,
                                           input logic bin, input logic old_cz, input logic bf);
    logic [8:0] d;
    logic [4:0] lo;
    logic ov;
    logic z;
    d = {1'b0, a} - {1'b0, m} - {8'h00, bin};
    lo = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, bin};
    ov = (a[7] != m[7]) && (d[7] != a[7]);
    z = (d[7:0] == 8'h00);
    return {bf ? (z & old_cz) : z, ov ^ d[7], ov, z, ~lo[4], ~d[8], d[7:0]};
  endfunction

  initial begin
    i_nrst = 1'b0;
    i_start = 1'b0;
    i_op = 5'h00;
    i_bit = 3'h0;
    i_mem_addr = '0;
    i_reg_addr = 3'h0;
    i_reg_wdata = 8'h00;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    for (int k = 0; k < 2**PM_AW; k++) begin
      eieu_mem_model_i.pm[k] = 16'h5000 | 16'(k);
    end
    repeat (6) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      st = {k[0], 4'h0, sc[k]};
      prep(sa[k], st, sm[k]);
      want = sub_calc(sa[k], sm[k], (k < 2) ? ~sc[k] : 1'b0, k[0], k < 2);
      exec(eieu_op_t'(k), 3'h0, n_cyc, skp);
      chk(o_status, want[13:8]);
      chk(o_acc, k[0] ? sa[k] : want[7:0]);
      chk(eieu_mem_model_i.dm[DADDR], k[0] ? want[7:0] : sm[k]);
      chk(16'(n_cyc), 16'h0003);
    end
    for (int k = 0; k < 20; k++) begin
      r = rows[k];
      prep(r.a0, 6'h15, r.m);
      exec(r.op, r.bt, n_cyc, skp);
      chk(skp, r.skip);
      chk(16'(n_cyc), 16'h0003 + r.skip);
      chk(o_acc, r.to_acc ? r.res : r.a0);
      chk(eieu_mem_model_i.dm[DADDR], r.to_acc ? r.m : r.res);
      xo = (r.op == OP_EXCLUSIVE_OR) || (r.op == OP_EXCLUSIVE_OR_MEM);
      chk(o_status, xo ? {3'b010, r.res == 8'h00, 2'b01} : 6'h15);
    end
    // Table reads: page, final page, and their pre-increment forms; FF wraps to 00
    reg_wr(`EIEU_REG_TABLE_POINTER_HIGH, 8'h0A);
    for (int k = 0; k < 4; k++) begin
      reg_wr(`EIEU_REG_TABLE_POINTER_LOW, (k == 3) ? 8'hFF : 8'h34);
      reg_wr(`EIEU_REG_STATUS, 8'h2A);
      pa = {k[0] ? 4'hF : 4'hA, ((k == 3) ? 8'hFF : 8'h34) + {7'h00, k[1]}};
      exec(eieu_op_t'(5'h11 + 5'(k)), 3'h0, n_cyc, skp);
      chk(16'(n_cyc), 16'h0004 + k[1]);
      chk(o_table_pointer_low, pa[7:0]);
      chk(eieu_mem_model_i.dm[DADDR], pa[7:0]);
      chk(o_status, 6'h2A);
      reg_rd(`EIEU_REG_TABLE_HIGH_BYTE, rd_val);
      chk(rd_val, {4'h5, pa[11:8]});
    end
    reg_rd(3'h6, rd_val);
    chk(rd_val, 8'h00);
    reg_wr(`EIEU_REG_CTRL, 8'hFF);
    reg_rd(`EIEU_REG_CTRL, rd_val);
    chk(rd_val, 8'h00);
    reg_rd(`EIEU_REG_ACC, rd_val);
    chk(rd_val, 8'h5A);
    @(posedge i_sys_clk);
    #1 chk(o_reg_rdata, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
